// [tsps_chk.sv]
/* Port assertions for the tap sign and posture block.
   Assumes it is bound to tsps_top and that the master holds requests. */
`timescale 1ns/1ps
module tsps_chk
(
	// Watched ports.
	input wire logic        mclk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  address_i,
	input wire logic        read_i,
	input wire logic        write_i,
	input wire logic [3:0]  byteenable_i,
	input wire logic        sample_valid_i,
	input wire logic        standby_i,
	input wire logic [31:0] readdata_o,
	input wire logic        waitrequest_o,
	input wire logic        shared_event_o,
	input wire logic        posture_pending_o
);
	// ****
	// Assertions, all in the one clock domain.
	// ****
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Accepted read, named so the clear checks stay readable.
	wire logic acc_rd = read_i && !waitrequest_o;
	// Accepted low-lane write.
	wire logic acc_wr = write_i && !waitrequest_o && byteenable_i[0];

	AST_BUS: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("access not answered after one wait cycle");
	AST_UNMAP: assert property (acc_rd && address_i == 8'h00 |-> readdata_o == 32'h0)
		else $error("unmapped read not zero");
	AST_STBY: assert property (standby_i |=> !posture_pending_o)
		else $error("standby left event pending");
	AST_RATE: assert property (acc_wr && address_i == 8'h41 |=> !posture_pending_o)
		else $error("rate write left event pending");
	AST_CAUSE: assert property (acc_rd && address_i == 8'h30 && readdata_o[0] && !sample_valid_i
		&& !$past(sample_valid_i) |=> !posture_pending_o)
		else $error("cause read did not clear event");
	AST_SET: assert property ($rose(posture_pending_o) |-> $past(sample_valid_i)
		|| $past(sample_valid_i, 2))
		else $error("event rose without a sample");
	AST_SHARE: assert property (posture_pending_o |-> shared_event_o)
		else $error("shared position hides posture event");
	AST_CLR: assert property ($fell(posture_pending_o) |-> $past(read_i) || $past(write_i)
		|| $past(standby_i))
		else $error("event cleared with no cause");
	// Main scenarios reached.
	CV_SET: cover property ($rose(posture_pending_o));
	CV_CAUSE: cover property (acc_rd && address_i == 8'h30 && readdata_o[0]);
	CV_STBY: cover property (standby_i && posture_pending_o);
endmodule : tsps_chk

bind tsps_top tsps_chk i_chk (.mclk_i(mclk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
	.write_i(write_i), .byteenable_i(byteenable_i), .sample_valid_i(sample_valid_i),
	.standby_i(standby_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
	.shared_event_o(shared_event_o), .posture_pending_o(posture_pending_o));

// [tsps_defs.svh]
/*
 * Register offsets, field positions, reset values and guard band ratios
 * for the tap sign and posture status block.
 * Assumes it is included once, by the block's module only.
 */
`ifndef TSPS_DEFS_SVH
`define TSPS_DEFS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define TSPS_IDX_CAUSE      8'h30
`define TSPS_IDX_TAP_DIR    8'h3a
`define TSPS_IDX_CONFIG     8'h3b
`define TSPS_IDX_STATUS     8'h3c
`define TSPS_IDX_TAP_AXES   8'h40
`define TSPS_IDX_RATE       8'h41

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define TSPS_CFG_EN_BIT     7
`define TSPS_CFG_SOLID_BIT  3
`define TSPS_CAUSE_SHARED   0
`define TSPS_CONFIG_RST     8'h00
`define TSPS_TAP_AXES_RST   3'h0
`define TSPS_RATE_RST       8'h0a

// ****************************************************************
// Guard band ratios tan(45 deg + angle) in units of 1/64.
// Flat: 3.3 5.8 8.2 10.3 12.3 14.1 15.6 17.0 degrees.
// Solid: 2.5 6.3 9.8 13.0 16.0 18.6 20.9 23.0 degrees.
// ****************************************************************
`define TSPS_RATIO_ONE      8'h40
`define TSPS_FLAT_RATIOS    {8'h78, 8'h70, 8'h6a, 8'h63, 8'h5c, 8'h55, 8'h4e, 8'h48}
`define TSPS_SOLID_RATIOS   {8'h9e, 8'h8f, 8'h81, 8'h73, 8'h66, 8'h5a, 8'h50, 8'h46}

`endif

// [tsps_host.sv]
/* Host processor model: an Avalon-MM master with register tasks.
   Assumes a slave that answers through waitrequest on mclk_i. */
`timescale 1ns/1ps
module tsps_host
(
	// Clock and slave answer.
	input  wire logic        mclk_i,
	input  wire logic [31:0] readdata_i,
	input  wire logic        waitrequest_i,
	// Master request.
	output logic [7:0]       address_o = 8'h0,
	output logic             read_o = 1'b0,
	output logic             write_o = 1'b0,
	output logic [3:0]       byteenable_o = 4'h1,
	output logic [31:0]      writedata_o = 32'h0
);
	// ****
	// Bus cycles; idle data is inverted so a stale value never reads as good.
	// ****
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		address_o   <= a;
		writedata_o <= {24'h0, d};
		write_o     <= 1'b1;
		do @(posedge mclk_i); while (waitrequest_i);
		write_o     <= 1'b0;
		writedata_o <= ~{24'h0, d};
	endtask : wr

	// Read data is taken at the same edge that ends the wait.
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge mclk_i);
		address_o <= a;
		read_o    <= 1'b1;
		do @(posedge mclk_i); while (waitrequest_i);
		q = readdata_i;
		read_o    <= 1'b0;
		address_o <= ~a;
	endtask : rd
endmodule : tsps_host

// [tsps_pkg.sv]
/*
 * Types shared by the tap sign and posture status block.
 * Assumes nothing of its surroundings.
 */
package tsps_pkg;

	// Flat (two axis) and solid (three axis) posture codes.
	typedef logic [1:0] tsps_flat_t;
	typedef logic [2:0] tsps_solid_t;

	// Per-axis triple, bit 2 is X, bit 1 is Y, bit 0 is Z.
	typedef logic [2:0] tsps_axes_t;

endpackage : tsps_pkg

// [tsps_top.sv]
/*
 * Tap direction flags and posture (orientation) detector with an
 * Avalon-MM register slave using word addresses.
 * Assumes tap detection, overrun detection, standby control and the
 * acceleration sample stream come from logic on the same clock.
 */
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tsps_defs.svh"

module tsps_top
	import tsps_pkg::*;
(
	// Clock and reset.
	input  wire logic               mclk_i,
	input  wire logic               rst_i,
	// Avalon-MM slave, word addressed.
	input  wire logic [7:0]         address_i,
	input  wire logic               read_i,
	input  wire logic               write_i,
	input  wire logic [3:0]         byteenable_i,
	input  wire logic [31:0]        writedata_i,
	output logic      [31:0]        readdata_o,
	output logic                    waitrequest_o,
	// Tap detector results.
	input  wire logic               tap_event_i,
	input  wire logic [2:0]         tap_first_axis_i,
	input  wire logic [2:0]         tap_negative_i,
	// Acceleration samples.
	input  wire logic               sample_valid_i,
	input  wire logic signed [15:0] accel_x_i,
	input  wire logic signed [15:0] accel_y_i,
	input  wire logic signed [15:0] accel_z_i,
	// Shared event position and power state.
	input  wire logic               overrun_i,
	input  wire logic               standby_i,
	output logic                    shared_event_o,
	output logic                    posture_pending_o
);

	// ****************************************************************
	// Bus slave.
	// ****************************************************************
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [7:0]  rdata_next;
	logic        req;
	logic        accept;
	logic        wr_acc;
	logic        rd_acc;

	// One wait cycle per access: data is gathered, then the access is taken.
	assign req           = read_i | write_i;
	assign waitrequest_o = req & ~ack_reg;
	assign accept        = req & ack_reg;
	assign wr_acc        = accept & write_i & byteenable_i[0];
	assign rd_acc        = accept & read_i;
	assign readdata_o    = rdata_reg;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= req & ~ack_reg;
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			rdata_reg <= 32'h0000_0000;
		else if (req & ~ack_reg)
			rdata_reg <= {24'h00_0000, rdata_next};
	end

	// ****************************************************************
	// Control registers.
	// ****************************************************************
	logic [7:0]  config_reg;
	logic [7:0]  rate_reg;
	tsps_axes_t  tap_axes_reg;
	logic        wr_config;
	logic        wr_rate;
	logic        posture_en;
	logic        solid_sel;
	logic [2:0]  guard_code;
	logic [3:0]  filt_shift;

	assign wr_config  = wr_acc & (address_i == `TSPS_IDX_CONFIG);
	assign wr_rate    = wr_acc & (address_i == `TSPS_IDX_RATE);
	assign posture_en = config_reg[`TSPS_CFG_EN_BIT];
	assign solid_sel  = config_reg[`TSPS_CFG_SOLID_BIT];
	assign guard_code = config_reg[6:4];
	assign filt_shift = {1'b0, config_reg[2:0]} + 4'h1;

	// Written only at the accepted edge, low byte lane only.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			config_reg   <= `TSPS_CONFIG_RST;
			rate_reg     <= `TSPS_RATE_RST;
			tap_axes_reg <= `TSPS_TAP_AXES_RST;
		end
		else if (wr_acc)
		begin
			if (wr_config)
				config_reg <= writedata_i[7:0];
			if (wr_rate)
				rate_reg <= writedata_i[7:0];
			if (address_i == `TSPS_IDX_TAP_AXES)
				tap_axes_reg <= writedata_i[2:0];
		end
	end

	// ****************************************************************
	// Tap direction flags.
	// ****************************************************************
	tsps_axes_t tap_neg_reg;
	tsps_axes_t tap_hit_reg;
	tsps_axes_t tap_neg_next;
	tsps_axes_t tap_hit_next;

	// Sign follows only enabled axes; a disabled axis keeps its old sign.
	assign tap_neg_next = (tap_negative_i & tap_axes_reg) | (tap_neg_reg & ~tap_axes_reg);
	// Overwritten at each tap; a disabled axis is forced to zero here.
	assign tap_hit_next = tap_first_axis_i & tap_axes_reg;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			tap_neg_reg <= 3'h0;
			tap_hit_reg <= 3'h0;
		end
		else if (tap_event_i)
		begin
			tap_neg_reg <= tap_neg_next;
			tap_hit_reg <= tap_hit_next;
		end
	end

	// ****************************************************************
	// Low-pass filter, one per axis.
	// ****************************************************************
	logic signed [15:0] accel_in   [3];
	logic signed [15:0] filt_reg   [3];
	logic signed [15:0] filt_next  [3];
	logic        [15:0] mag        [3];

	assign accel_in[0] = accel_x_i;
	assign accel_in[1] = accel_y_i;
	assign accel_in[2] = accel_z_i;

	// Exponential average with gain 1/2^(code+1); cheaper than a true
	// box average and it needs no sample history.
	for (genvar a = 0; a < 3; a++)
	begin : g_filt
		logic signed [16:0] diff;
		logic signed [16:0] step;
		assign diff         = 17'(accel_in[a]) - 17'(filt_reg[a]);
		assign step         = diff >>> filt_shift;
		assign filt_next[a] = 16'(17'(filt_reg[a]) + step);
		assign mag[a]       = filt_next[a][15] ? 16'(-filt_next[a]) : 16'(filt_next[a]);

		always_ff @(posedge mclk_i)
		begin
			if (rst_i | wr_rate)
				filt_reg[a] <= 16'h0000;
			else if (sample_valid_i)
				filt_reg[a] <= filt_next[a];
		end
	end

	// ****************************************************************
	// Posture classification.
	// ****************************************************************
	logic [63:0] flat_tab;
	logic [63:0] solid_tab;
	logic [7:0]  flat_ratio;
	logic [7:0]  solid_ratio;
	logic        x_over_y;
	logic [15:0] flat_dom;
	logic [15:0] flat_sub;
	logic        flat_ok;
	tsps_flat_t  flat_code;
	logic [1:0]  solid_axis;
	logic [15:0] solid_dom;
	logic [15:0] solid_sub;
	logic        solid_ok;
	tsps_solid_t solid_code;

	assign flat_tab    = `TSPS_FLAT_RATIOS;
	assign solid_tab   = `TSPS_SOLID_RATIOS;
	assign flat_ratio  = flat_tab[guard_code*8 +: 8];
	assign solid_ratio = solid_tab[guard_code*8 +: 8];

	// Flat: X against Y, valid only outside the guard band.
	assign x_over_y  = mag[0] >= mag[1];
	assign flat_dom  = x_over_y ? mag[0] : mag[1];
	assign flat_sub  = x_over_y ? mag[1] : mag[0];
	assign flat_ok   = (24'(flat_dom) * 24'(`TSPS_RATIO_ONE)) > (24'(flat_sub) * 24'(flat_ratio));
	assign flat_code = x_over_y ? {1'b0, filt_next[0][15]} : {1'b1, filt_next[1][15]};

	// Solid: largest axis against the runner-up.
	assign solid_axis = (mag[0] >= mag[1] && mag[0] >= mag[2]) ? 2'h0 :
	                    (mag[1] >= mag[2]) ? 2'h1 : 2'h2;
	assign solid_dom  = mag[solid_axis];
	assign solid_sub  = (solid_axis == 2'h0) ? ((mag[1] >= mag[2]) ? mag[1] : mag[2]) :
	                    (solid_axis == 2'h1) ? ((mag[0] >= mag[2]) ? mag[0] : mag[2]) :
	                    ((mag[0] >= mag[1]) ? mag[0] : mag[1]);
	assign solid_ok   = (24'(solid_dom) * 24'(`TSPS_RATIO_ONE)) > (24'(solid_sub) * 24'(solid_ratio));

	// Positive axes count 3, 2, 1 for X, Y, Z; negatives are 7 minus that.
	always_comb
	begin
		logic [2:0] base;
		base = 3'h3 - {1'b0, solid_axis};
		solid_code = filt_next[solid_axis][15] ? (3'h7 - base) : base;
	end

	// ****************************************************************
	// Posture status and event.
	// ****************************************************************
	logic        flat_valid_reg;
	logic        solid_valid_reg;
	tsps_flat_t  flat_code_reg;
	tsps_solid_t solid_code_reg;
	logic        flat_seen_reg;
	logic        solid_seen_reg;
	logic        pending_reg;
	logic        restart;
	logic        dis_wr;
	logic        flat_change;
	logic        solid_change;
	logic        event_set;
	logic        event_clr;
	logic        pending_next;

	assign restart = wr_rate;
	assign dis_wr  = wr_config & ~writedata_i[`TSPS_CFG_EN_BIT];

	// A change counts only from one stored valid code to another valid one.
	assign flat_change  = flat_ok & flat_seen_reg & (flat_code != flat_code_reg);
	assign solid_change = solid_ok & solid_seen_reg & (solid_code != solid_code_reg);
	assign event_set    = posture_en & sample_valid_i & ~restart & ~standby_i & ~dis_wr &
	                      (solid_sel ? solid_change : flat_change);

	// A read clears only what the host was shown, so a set in the same
	// window is kept for the next read.
	assign event_clr    = (rd_acc & (address_i == `TSPS_IDX_CAUSE) &
	                       rdata_reg[`TSPS_CAUSE_SHARED]) | wr_rate | standby_i | dis_wr;
	assign pending_next = posture_en & (event_set | (pending_reg & ~event_clr));

	always_ff @(posedge mclk_i)
	begin
		if (rst_i | restart)
		begin
			flat_valid_reg  <= 1'b0;
			solid_valid_reg <= 1'b0;
			flat_code_reg   <= 2'h0;
			solid_code_reg  <= 3'h0;
			flat_seen_reg   <= 1'b0;
			solid_seen_reg  <= 1'b0;
		end
		else if (sample_valid_i)
		begin
			flat_valid_reg  <= flat_ok;
			solid_valid_reg <= solid_ok;
			if (flat_ok)
			begin
				flat_code_reg <= flat_code;
				flat_seen_reg <= 1'b1;
			end
			if (solid_ok)
			begin
				solid_code_reg <= solid_code;
				solid_seen_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			pending_reg <= 1'b0;
		else
			pending_reg <= pending_next;
	end

	assign posture_pending_o = pending_reg;
	assign shared_event_o    = posture_en ? pending_reg : overrun_i;

	// ****************************************************************
	// Read multiplexer.
	// ****************************************************************
	always_comb
	begin
		unique case (address_i)
			`TSPS_IDX_CAUSE:    rdata_next = {7'h00, shared_event_o};
			`TSPS_IDX_TAP_DIR:  rdata_next = {1'b0, tap_neg_reg, 1'b0, tap_hit_reg};
			`TSPS_IDX_CONFIG:   rdata_next = config_reg;
			`TSPS_IDX_STATUS:   rdata_next = {1'b0, flat_valid_reg, flat_code_reg,
			                                  solid_valid_reg, solid_code_reg};
			`TSPS_IDX_TAP_AXES: rdata_next = {5'h00, tap_axes_reg};
			`TSPS_IDX_RATE:     rdata_next = rate_reg;
			default:            rdata_next = 8'h00;
		endcase
	end

endmodule : tsps_top

// [tsps_top_tb.sv]
/* Self-checking bench for the tap sign and posture block.
   Assumes tsps_host drives the bus and tsps_chk is bound to the design. */
`timescale 1ns/1ps
module tsps_top_tb;
	logic               mclk = 1'b0;
	logic               rst = 1'b1;
	logic               tap_ev = 1'b0, smp = 1'b0, ovr = 1'b0, stby = 1'b0;
	logic [2:0]         tap_ax = 3'h0, tap_ng = 3'h0;
	logic signed [15:0] ax = 16'sh0, ay = 16'sh0, az = 16'sh0;
	logic [7:0]         adr;
	logic               rd_s, wr_s, wreq, sev, pend;
	logic [3:0]         be;
	logic [31:0]        wd, rdat, q;
	int                 n_mismatch = 0, n_compared = 0;
	// One axis sweep per row: sample, expected status, expected event.
	typedef struct {logic signed [15:0] x, y, z; logic [31:0] st; logic pd;} tsps_row_t;
	tsps_row_t rows [4] = '{'{16'sd4000, 16'sd0, 16'sd0, 32'h4b, 1'b0}, '{-16'sd4000, 16'sd0, 16'sd0, 32'h5c, 1'b1},
		'{16'sd0, 16'sd4000, 16'sd0, 32'h6a, 1'b1}, '{16'sd0, -16'sd4000, 16'sd0, 32'h7d, 1'b1}};

	always #5 mclk = ~mclk;

	tsps_top i_dut (.mclk_i(mclk), .rst_i(rst), .address_i(adr), .read_i(rd_s), .write_i(wr_s),
		.byteenable_i(be), .writedata_i(wd), .readdata_o(rdat), .waitrequest_o(wreq),
		.tap_event_i(tap_ev), .tap_first_axis_i(tap_ax), .tap_negative_i(tap_ng),
		.sample_valid_i(smp), .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az), .overrun_i(ovr),
		.standby_i(stby), .shared_event_o(sev), .posture_pending_o(pend));
	tsps_host i_host (.mclk_i(mclk), .readdata_i(rdat), .waitrequest_i(wreq), .address_o(adr),
		.read_o(rd_s), .write_o(wr_s), .byteenable_o(be), .writedata_o(wd));

	// ****
	// Shared tasks.
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic rr(input logic [7:0] a, input logic [31:0] exp);
		i_host.rd(a, q);
		check(q, exp);
	endtask : rr

	// Samples are spaced two cycles apart so every pulse is one cycle wide.
	task automatic feed(input logic signed [15:0] x, y, z);
		repeat (24)
		begin
			@(posedge mclk);
			smp <= 1'b1; ax <= x; ay <= y; az <= z;
			@(posedge mclk);
			smp <= 1'b0;
		end
	endtask : feed

	task automatic tap(input logic [2:0] f, input logic [2:0] n);
		@(posedge mclk);
		tap_ev <= 1'b1; tap_ax <= f; tap_ng <= n;
		@(posedge mclk);
		tap_ev <= 1'b0; tap_ax <= ~f; tap_ng <= ~n;
	endtask : tap

	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	// Watchdog well beyond the roughly 650 cycles the tests need.
	initial
	begin
		#200000;
		n_mismatch++;
		summarize();
	end

	// ****
	// Main sequence.
	// ****
	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		rr(8'h3b, 32'h0);
		rr(8'h41, 32'h0a);
		rr(8'h00, 32'h0);
		i_host.wr(8'h40, 8'h07);
		tap(3'b100, 3'b100);
		rr(8'h3a, 32'h44);
		i_host.wr(8'h40, 8'h03);
		rr(8'h3a, 32'h44);
		tap(3'b010, 3'b000);
		rr(8'h3a, 32'h42);
		$display("tap test done");
		i_host.wr(8'h3b, 8'h90);
		foreach (rows[i])
		begin
			feed(rows[i].x, rows[i].y, rows[i].z);
			rr(8'h3c, rows[i].st);
			check(pend, rows[i].pd);
			rr(8'h30, rows[i].pd);
			// The clear lands at the accepting edge; look one edge later.
			@(posedge mclk);
			check(pend, 1'b0);
		end
		$display("flat posture test done");
		i_host.wr(8'h41, 8'h0a);
		rr(8'h3c, 32'h0);
		feed(16'sd0, 16'sd0, 16'sd4000);
		rr(8'h3c, 32'h09);
		feed(16'sd0, 16'sd0, -16'sd4000);
		rr(8'h3c, 32'h0e);
		check(pend, 1'b0);
		i_host.wr(8'h3b, 8'h98);
		feed(16'sd0, 16'sd0, 16'sd4000);
		rr(8'h3c, 32'h09);
		check(pend, 1'b1);
		check(sev, 1'b1);
		@(posedge mclk);
		stby <= 1'b1;
		@(posedge mclk);
		stby <= 1'b0;
		@(posedge mclk);
		check(pend, 1'b0);
		feed(16'sd0, 16'sd0, -16'sd4000);
		check(pend, 1'b1);
		i_host.wr(8'h3b, 8'h18);
		ovr <= 1'b1;
		@(posedge mclk);
		check(pend, 1'b0);
		check(sev, 1'b1);
		rr(8'h30, 32'h1);
		$display("solid posture test done");
		// Tilt about 6.8 degrees off the X-Y bisector: inside band code 2, outside band code 1.
		i_host.wr(8'h41, 8'h0a);
		i_host.wr(8'h3b, 8'h20);
		feed(16'sh0fa0, 16'sh0c4e, 16'sh0000);
		rr(8'h3c, 32'h00);
		i_host.wr(8'h3b, 8'h10);
		feed(16'sh0fa0, 16'sh0c4e, 16'sh0000);
		rr(8'h3c, 32'h4b);
		// Deepest filter: 24 samples move the average too little to leave the X posture.
		i_host.wr(8'h3b, 8'h17);
		feed(16'sh0000, 16'sh0fa0, 16'sh0000);
		rr(8'h3c, 32'h03);
		$display("guard and filter test done");
		summarize();
	end
endmodule : tsps_top_tb
